/* aicf_chk.sv */
// port assertions for the ascii command framer
`timescale 1ns/1ps
module aicf_chk #(
  parameter int NAK_CYCLES  = 200,
  parameter int DROP_CYCLES = 1000
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic [9:0] output_points_one_to_ten
);
  // ====
  // helpers
  logic       pop;
  logic [7:0] pos_q;
  logic [7:0] last_q;
  logic       open_q;
  logic       cr_q;
  logic       saw_q;
  int         age_q;
  assign pop = tx_valid && tx_ready;
  // byte position inside the reply frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_q  <= 8'h00;
      last_q <= 8'h00;
    end else if (pop) begin
      pos_q  <= (tx_data == 8'h0A) ? 8'h00 : pos_q + 8'h01;
      last_q <= tx_data;
    end
  end
  // age of the open received frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      open_q <= 1'b0;
      cr_q   <= 1'b0;
      age_q  <= 0;
    end else if (rx_valid && rx_data == 8'h3A) begin
      open_q <= 1'b1;
      cr_q   <= 1'b0;
      age_q  <= 0;
    end else begin
      if (open_q) age_q <= age_q + 1;
      if (rx_valid && (rx_data == 8'h0A || cr_q)) open_q <= 1'b0;
      if (rx_valid) cr_q <= (rx_data == 8'h0D);
    end
  end
  // any reply byte seen since the last start byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) saw_q <= 1'b0;
    else if (rx_valid && rx_data == 8'h3A) saw_q <= 1'b0;
    else if (tx_valid) saw_q <= 1'b1;
  end
  // ====
  // assertions
  chk_rx_always_ready: assert property (@(posedge clk) disable iff (reset) rx_ready)
    else $error("rx_ready low");
  chk_tx_byte_hold: assert property (@(posedge clk) disable iff (reset)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte not held");
  chk_frame_start: assert property (@(posedge clk) disable iff (reset)
    pop && pos_q == 8'h00 |-> tx_data == 8'h3A) else $error("reply not opened by start");
  chk_lf_after_cr: assert property (@(posedge clk) disable iff (reset)
    pop && tx_data == 8'h0A |-> last_q == 8'h0D) else $error("lf without cr");
  chk_len_high: assert property (@(posedge clk) disable iff (reset)
    pop && pos_q == 8'h01 |-> tx_data == 8'h30 || tx_data == 8'h33) else $error("bad length high");
  chk_len_low: assert property (@(posedge clk) disable iff (reset)
    pop && pos_q == 8'h02 |-> tx_data == 8'h35 || tx_data == 8'h36) else $error("bad length low");
  chk_func_high: assert property (@(posedge clk) disable iff (reset)
    pop && pos_q == 8'h03 |-> tx_data == 8'h30) else $error("bad function high");
  chk_nak_late: assert property (@(posedge clk) disable iff (reset)
    open_q && age_q == NAK_CYCLES + 8 |-> saw_q) else $error("no reply to late frame");
  chk_outs_on_lf: assert property (@(posedge clk) disable iff (reset)
    !$stable(output_points_one_to_ten) |-> $past(rx_valid && rx_data == 8'h0A))
    else $error("outputs moved without lf");
endmodule : aicf_chk

bind aicf_framer aicf_chk #(.NAK_CYCLES(NAK_CYCLES), .DROP_CYCLES(DROP_CYCLES)) chk_i (
  .clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .output_points_one_to_ten(output_points_one_to_ten));

/* aicf_fifo.sv */
// byte fifo between the reply builder and the link transmitter
`timescale 1ns/1ps
module aicf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // ==========================================================================
  // handshakes
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : aicf_fifo

/* aicf_framer.sv */
// ascii-hex command receiver, on/off decoder and reply frame builder
// Notes on behaviour
// R1: frames open with 0x3A and close with CR 0x0D then LF 0x0A.
// R2: length field, two hex chars, counts function plus data bytes.
// R3: two-byte function field follows length: command or response code.
// R4: check field is XOR of start through data, two hex chars before CR.
// R5: hex bytes sent upper nibble first; 0-9 as 0x30.., A-F as 0x41..
// R6: received hex pairs converted back to binary before comparing.
// R7: reception abandoned when LF missing 5 s after start byte.
// R8: bad check or timeout: discard command, wait for next start byte.
// R9: host waits at least 5 s for a reply before giving up.
// R10: check mismatch answered with NAK frame: function "00", data "NAK".
// R11: NAK sent when a frame is incomplete 1 s after its start.
// R12: NAK sent when received body count differs from length field.
// R13: host retransmits or reports on receiving a NAK.
// R14: function "01" is the batch on/off update of ten outputs.
// R15: data bytes 1-10 are masks for outputs 1-10; 0x31 selects.
// R16: data byte 11 is the separator 0x2C.
// R17: data bytes 12-21 are states for outputs 1-10; 0x31 on.
// R18: accepted on/off answered with code "02" and 52 state bytes.
// R19: first state byte: 0x30 normal, 0x31 not running, 0x39 abnormal.
// R20: bytes outside a frame ignored; new start byte restarts assembly.
// R21: 1 s NAK limit and 5 s discard limit are separate parameters.
// R22: outputs with mask 0x30 keep their state.
`timescale 1ns/1ps
module aicf_framer #(
  parameter int NAK_CYCLES  = aicf_pkg::NAK_CYCLES,
  parameter int DROP_CYCLES = aicf_pkg::DROP_CYCLES,
  parameter int FIFO_DEPTH  = aicf_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  input  wire logic [11:0] input_points,
  input  wire logic        run_mode,
  input  wire logic        control_fault,
  output logic [9:0]       output_points_one_to_ten
);

  // ==========================================================================
  // helpers
  // hex char to nibble, bit 4 flags an illegal char
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= aicf_pkg::CH_ZERO && c <= aicf_pkg::CH_NINE) begin
      hex_nib = {1'b0, 4'(c - aicf_pkg::CH_ZERO)};
    end else if (c >= aicf_pkg::CH_UA && c <= aicf_pkg::CH_UF) begin
      hex_nib = {1'b0, 4'(c - aicf_pkg::CH_UA + 8'h0A)};
    end else begin
      hex_nib = 5'h10;
    end
  endfunction : hex_nib

  // nibble to hex char
  function automatic logic [7:0] nib_hex(input logic [3:0] n);
    if (n < 4'hA) begin
      nib_hex = aicf_pkg::CH_ZERO + {4'h0, n};
    end else begin
      nib_hex = aicf_pkg::CH_UA + {4'h0, n - 4'hA};
    end
  endfunction : nib_hex

  // one data byte of the state reply, idx counts from 1
  function automatic logic [7:0] state_byte(input logic [6:0] idx, input logic [7:0] status,
                                            input logic [11:0] ins, input logic [9:0] outs);
    logic [6:0] ii;
    logic [6:0] oi;
    ii = idx - 7'd26 - 7'(idx > 7'd30) - 7'(idx > 7'd35);
    oi = idx - 7'd41 - 7'(idx > 7'd45) - 7'(idx > 7'd50);
    if (idx == 7'd1) begin
      state_byte = status;
    end else if (idx == 7'd7 || idx == 7'd13 || idx == 7'd19 || idx == 7'd25 || idx == 7'd30 ||
                 idx == 7'd35 || idx == 7'd40 || idx == 7'd45 || idx == 7'd50) begin
      state_byte = aicf_pkg::CH_SEP;
    end else if (idx < 7'd25) begin
      state_byte = aicf_pkg::CH_ZERO;       // analog fields read off / zero level
    end else if (idx < 7'd40) begin
      state_byte = ins[ii[3:0]] ? aicf_pkg::CH_ONE : aicf_pkg::CH_ZERO;
    end else begin
      state_byte = outs[oi[3:0]] ? aicf_pkg::CH_ONE : aicf_pkg::CH_ZERO;
    end
  endfunction : state_byte

  // ==========================================================================
  // pin synchronisers
  logic [11:0] in_meta_q;
  logic [11:0] in_sync_q;
  logic [1:0]  st_meta_q;
  logic [1:0]  st_sync_q;

  // two flops on every asynchronous pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
      st_meta_q <= '0;
      st_sync_q <= '0;
    end else begin
      in_meta_q <= input_points;
      in_sync_q <= in_meta_q;
      st_meta_q <= {control_fault, run_mode};
      st_sync_q <= st_meta_q;
    end
  end

  // ==========================================================================
  // receiver
  aicf_pkg::aicf_rx_t rx_q;
  logic [7:0]  len_q;
  logic [7:0]  cnt_q;
  logic [7:0]  xor_q;
  logic [7:0]  h1_q;
  logic [7:0]  h0_q;
  logic        herr_q;
  logic [7:0]  func_q;
  logic        sep_ok_q;
  logic [9:0]  mask_q;
  logic [9:0]  want_q;
  logic [25:0] tmr_q;
  logic        nak_sent_q;
  logic [4:0]  nib;
  logic [4:0]  c_hi;
  logic [4:0]  c_lo;
  logic        is_start;
  logic        at_lf;
  logic        chk_ok;
  logic        len_ok;
  logic        frame_ok;
  logic        tmo_nak;
  logic        tmo_drop;
  logic        nak_req;
  logic        st_req;
  logic        do_onoff;

  assign rx_ready = 1'b1;                   // bytes are never refused
  assign nib      = hex_nib(rx_data);
  assign c_hi     = hex_nib(h1_q);
  assign c_lo     = hex_nib(h0_q);
  assign is_start = rx_valid && rx_data == aicf_pkg::CH_START;
  assign at_lf    = rx_valid && rx_q == aicf_pkg::RX_LF && rx_data == aicf_pkg::CH_LF;
  assign chk_ok   = !c_hi[4] && !c_lo[4] && {c_hi[3:0], c_lo[3:0]} == (xor_q ^ h1_q ^ h0_q); // R4 R6
  assign len_ok   = cnt_q >= 8'd2 && cnt_q != 8'hFF && (cnt_q - 8'd2) == len_q;               // R12
  assign frame_ok = chk_ok && len_ok && !herr_q;
  assign tmo_nak  = rx_q != aicf_pkg::RX_IDLE && tmr_q == 26'(NAK_CYCLES - 1);                 // R11
  assign tmo_drop = rx_q != aicf_pkg::RX_IDLE && tmr_q == 26'(DROP_CYCLES - 1);                // R7 R21
  assign nak_req  = !nak_sent_q && (tmo_nak || (at_lf && !frame_ok && !is_start));            // R10 R12
  assign do_onoff = at_lf && frame_ok && nak_sent_q == 1'b0 && func_q == aicf_pkg::CH_ONE &&
                    len_q == aicf_pkg::LEN_ONOFF && sep_ok_q;                                 // R14 R16
  assign st_req   = do_onoff;                                                                 // R18

  // frame state: start flag, length, body to CR, then LF
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_q <= aicf_pkg::RX_IDLE;
    end else if (is_start) begin
      rx_q <= aicf_pkg::RX_LEN_HI;          // R1 R20
    end else if (tmo_drop) begin
      rx_q <= aicf_pkg::RX_IDLE;            // R7 R8
    end else if (rx_valid) begin
      unique case (rx_q)
        aicf_pkg::RX_IDLE:   rx_q <= aicf_pkg::RX_IDLE;       // R20
        aicf_pkg::RX_LEN_HI: rx_q <= aicf_pkg::RX_LEN_LO;     // R2
        aicf_pkg::RX_LEN_LO: rx_q <= aicf_pkg::RX_BODY;
        aicf_pkg::RX_BODY:   rx_q <= (rx_data == aicf_pkg::CH_CR) ? aicf_pkg::RX_LF : aicf_pkg::RX_BODY; // R1
        aicf_pkg::RX_LF:     rx_q <= aicf_pkg::RX_IDLE;       // R8
        default:             rx_q <= aicf_pkg::RX_IDLE;
      endcase
    end
  end

  // length, running check and the last two body bytes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      len_q  <= '0;
      cnt_q  <= '0;
      xor_q  <= '0;
      h1_q   <= '0;
      h0_q   <= '0;
      herr_q <= 1'b0;
    end else if (is_start) begin
      cnt_q  <= '0;
      xor_q  <= aicf_pkg::CH_START;         // R4
      herr_q <= 1'b0;
    end else if (rx_valid) begin
      if (rx_q == aicf_pkg::RX_LEN_HI || rx_q == aicf_pkg::RX_LEN_LO) begin
        len_q  <= {len_q[3:0], nib[3:0]};   // R5 R6
        herr_q <= herr_q | nib[4];
        xor_q  <= xor_q ^ rx_data;
      end else if (rx_q == aicf_pkg::RX_BODY && rx_data != aicf_pkg::CH_CR) begin
        cnt_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'd1;
        xor_q <= xor_q ^ rx_data;           // R4
        h1_q  <= h0_q;
        h0_q  <= rx_data;
      end
    end
  end

  // function code and on/off fields captured by body position
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      func_q   <= '0;
      sep_ok_q <= 1'b0;
    end else if (rx_valid && rx_q == aicf_pkg::RX_BODY && rx_data != aicf_pkg::CH_CR) begin
      if (cnt_q == 8'd0) begin
        func_q <= (rx_data == aicf_pkg::CH_ZERO) ? 8'h00 : 8'hFF;                // R3
      end else if (cnt_q == 8'd1 && func_q == 8'h00) begin
        func_q <= rx_data;                  // R3
      end
      if (cnt_q == 8'(aicf_pkg::SEP_POS)) begin
        sep_ok_q <= rx_data == aicf_pkg::CH_SEP;                                  // R16
      end
    end
  end

  // per output mask and state bytes, then the update itself
  for (genvar g = 0; g < aicf_pkg::NUM_OUT; g++) begin : g_out
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mask_q[g] <= 1'b0;
        want_q[g] <= 1'b0;
      end else if (rx_valid && rx_q == aicf_pkg::RX_BODY) begin
        if (cnt_q == 8'(2 + g)) begin
          mask_q[g] <= rx_data == aicf_pkg::CH_ONE;                               // R15
        end
        if (cnt_q == 8'(aicf_pkg::SEP_POS + 1 + g)) begin
          want_q[g] <= rx_data == aicf_pkg::CH_ONE;                               // R17
        end
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        output_points_one_to_ten[g] <= aicf_pkg::OUT_RESET[g];
      end else if (do_onoff && mask_q[g]) begin
        output_points_one_to_ten[g] <= want_q[g];                                 // R15 R17
      end
    end                                      // unmasked outputs hold, R22
  end

  // frame age timer and one nak per frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmr_q      <= '0;
      nak_sent_q <= 1'b0;
    end else if (is_start) begin
      tmr_q      <= '0;                     // R20
      nak_sent_q <= 1'b0;
    end else if (rx_q != aicf_pkg::RX_IDLE) begin
      tmr_q      <= tmr_q + 26'd1;
      nak_sent_q <= nak_sent_q | nak_req;   // R11
    end
  end

  // ==========================================================================
  // reply builder
  logic       nak_pend_q;
  logic       st_pend_q;
  logic       busy_q;
  logic       kind_q;                       // 1 for nak, 0 for state reply
  logic [6:0] pos_q;
  logic [7:0] txx_q;
  logic [7:0] blen;
  logic [6:0] last;
  logic [6:0] didx;
  logic [7:0] status;
  logic [7:0] body_b;
  logic [7:0] out_b;
  logic       f_ready;
  logic       push;
  logic       start_tx;

  assign blen     = kind_q ? aicf_pkg::LEN_NAK : aicf_pkg::LEN_STATE;
  assign last     = 7'(blen) + 7'd6;
  assign didx     = pos_q - 7'd4;
  assign status   = st_sync_q[1] ? aicf_pkg::CH_NINE :
                    (st_sync_q[0] ? aicf_pkg::CH_ZERO : aicf_pkg::CH_NOTRUN);  // R19
  assign push     = busy_q;
  assign start_tx = !busy_q && (nak_pend_q || st_pend_q);

  // body bytes: function code then data
  always_comb begin
    if (pos_q == 7'd3) begin
      body_b = aicf_pkg::CH_ZERO;
    end else if (pos_q == 7'd4) begin
      body_b = kind_q ? aicf_pkg::CH_ZERO : aicf_pkg::CH_TWO;                     // R10 R18
    end else if (kind_q) begin
      body_b = (didx == 7'd1) ? aicf_pkg::CH_N : ((didx == 7'd2) ? aicf_pkg::CH_UA : aicf_pkg::CH_K); // R10
    end else begin
      body_b = state_byte(didx, status, in_sync_q, output_points_one_to_ten);     // R18
    end
  end

  // byte at the current frame position
  always_comb begin
    if (pos_q == 7'd0) begin
      out_b = aicf_pkg::CH_START;           // R1
    end else if (pos_q == 7'd1) begin
      out_b = nib_hex(blen[7:4]);           // R2 R5
    end else if (pos_q == 7'd2) begin
      out_b = nib_hex(blen[3:0]);
    end else if (pos_q < last - 7'd3) begin
      out_b = body_b;
    end else if (pos_q == last - 7'd3) begin
      out_b = nib_hex(txx_q[7:4]);          // R4 R5
    end else if (pos_q == last - 7'd2) begin
      out_b = nib_hex(txx_q[3:0]);
    end else if (pos_q == last - 7'd1) begin
      out_b = aicf_pkg::CH_CR;              // R1
    end else begin
      out_b = aicf_pkg::CH_LF;
    end
  end

  // pending requests, a new request beats the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nak_pend_q <= 1'b0;
      st_pend_q  <= 1'b0;
    end else begin
      nak_pend_q <= nak_req | (nak_pend_q & !(start_tx && nak_pend_q));
      st_pend_q  <= st_req | (st_pend_q & !(start_tx && !nak_pend_q));
    end
  end

  // position walk, stalled while the fifo is full
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      kind_q <= 1'b0;
      pos_q  <= '0;
      txx_q  <= '0;
    end else if (start_tx) begin
      busy_q <= 1'b1;
      kind_q <= nak_pend_q;
      pos_q  <= '0;
      txx_q  <= '0;
    end else if (busy_q && f_ready) begin
      if (pos_q < last - 7'd3) begin
        txx_q <= txx_q ^ out_b;             // R4
      end
      pos_q  <= pos_q + 7'd1;
      busy_q <= pos_q != last;
    end
  end

  // ==========================================================================
  // reply fifo toward the link
  aicf_fifo #(
    .WIDTH (aicf_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (out_b),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

endmodule : aicf_framer

/* aicf_framer_tb.sv */
// testbench for the ascii command framer
`timescale 1ns/1ps
module aicf_framer_tb;
  typedef logic [7:0] aicf_bq_t[$];
  localparam int NAKC  = 200;
  localparam int DROPC = 1000;
  logic        clk, reset, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        run_mode, control_fault, stall;
  logic [7:0]  rx_data, tx_data;
  logic [11:0] input_points;
  logic [9:0]  outs;
  int          miscompares, total_checks, cycles;

  aicf_framer #(.NAK_CYCLES(NAKC), .DROP_CYCLES(DROPC), .FIFO_DEPTH(32)) uut (
    .clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .input_points(input_points),
    .run_mode(run_mode), .control_fault(control_fault), .output_points_one_to_ten(outs));
  aicf_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .stall(stall));

  // ====
  // frame building
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  // wrap a body in start, length, check and end bytes
  function automatic aicf_bq_t mk(input aicf_bq_t b, input int adj, input logic [7:0] flip);
    aicf_bq_t   f;
    logic [7:0] n;
    logic [7:0] c;
    n = 8'(b.size() + adj);
    f = {8'h3A, hx(n[7:4]), hx(n[3:0]), b};
    c = flip;
    foreach (f[i]) c = c ^ f[i];
    return {f, hx(c[7:4]), hx(c[3:0]), 8'h0D, 8'h0A};
  endfunction : mk
  function automatic aicf_bq_t onoff(input logic [9:0] m, input logic [9:0] s);
    aicf_bq_t b;
    b = {8'h30, 8'h31};
    for (int g = 0; g < 10; g++) b.push_back(m[g] ? 8'h31 : 8'h30);
    b.push_back(8'h2C);
    for (int g = 0; g < 10; g++) b.push_back(s[g] ? 8'h31 : 8'h30);
    return b;
  endfunction : onoff
  // expected state reply
  function automatic aicf_bq_t st(input logic [7:0] stat, input logic [9:0] o);
    aicf_bq_t d;
    d = {8'h30, 8'h32, stat};
    for (int i = 1; i < 52; i++) d.push_back(8'h30);
    for (int k = 0; k < 4; k++) d[8 + 6 * k] = 8'h2C;
    for (int k = 0; k < 5; k++) d[31 + 5 * k] = 8'h2C;
    for (int i = 0; i < 12; i++) d[27 + i + i / 4] = input_points[i] ? 8'h31 : 8'h30;
    for (int i = 0; i < 10; i++) d[42 + i + i / 4] = o[i] ? 8'h31 : 8'h30;
    return mk(d, 0, 8'h00);
  endfunction : st
  function automatic aicf_bq_t nakf();
    return mk({8'h30, 8'h30, 8'h4E, 8'h41, 8'h4B}, 0, 8'h00);
  endfunction : nakf

  // ====
  // compares and transfers
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp_outs(input logic [9:0] e);
    total_checks++;
    if (outs !== e) begin
      miscompares++;
      $display("Error at %0t: outputs %h expected %h", $time, outs, e);
    end
  endtask : cmp_outs
  // send a command, then judge every reply byte
  task automatic xfer(input aicf_bq_t cmd, input aicf_bq_t exp);
    int n;
    host.got.delete();
    foreach (cmd[i]) host.txq.push_back(cmd[i]);
    n = 0;
    while ((host.txq.size() > 0 || host.got.size() < exp.size()) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
    cmp8(8'(host.got.size()), 8'(exp.size()));
    foreach (exp[i]) cmp8((i < host.got.size()) ? host.got[i] : 8'hXX, exp[i]);
  endtask : xfer

  // ====
  // scenarios
  task automatic t_onoff;
    logic [9:0] v[3];
    logic [7:0] sv[3];
    v  = '{10'h2B5, 10'h14A, 10'h3FF};
    sv = '{8'h30, 8'h31, 8'h39};
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      #1;
      run_mode      = (s != 1);
      control_fault = (s == 2);
      repeat (4) @(posedge clk);
      xfer(mk(onoff(10'h3FF, v[s]), 0, 8'h00), st(sv[s], v[s]));
      cmp_outs(v[s]);
    end
    $display("t_onoff done");
  endtask : t_onoff
  task automatic t_mask;
    stall = 1'b1;
    xfer(mk(onoff(10'h00F, 10'h005), 0, 8'h00), st(8'h39, 10'h3F5));
    cmp_outs(10'h3F5);
    stall = 1'b0;
    $display("t_mask done");
  endtask : t_mask
  task automatic t_bad;
    aicf_bq_t b;
    aicf_bq_t none;
    b = onoff(10'h3FF, 10'h000);
    b[12] = 8'h3B;
    xfer(mk(onoff(10'h3FF, 10'h000), 0, 8'h01), nakf());
    cmp_outs(10'h3F5);
    xfer(mk(onoff(10'h3FF, 10'h000), -1, 8'h00), nakf());
    cmp_outs(10'h3F5);
    // good check but wrong separator: no action, no reply
    xfer(mk(b, 0, 8'h00), none);
    cmp_outs(10'h3F5);
    // good frame with another function code: no action
    xfer(mk({8'h30, 8'h33, 8'h30}, 0, 8'h00), none);
    cmp_outs(10'h3F5);
    // host retransmits the refused command after the nak
    xfer(mk(onoff(10'h3FF, 10'h000), 0, 8'h00), st(8'h39, 10'h000));
    cmp_outs(10'h000);
    $display("t_bad done");
  endtask : t_bad
  task automatic t_late;
    aicf_bq_t f;
    aicf_bq_t none;
    f = mk(onoff(10'h3FF, 10'h3FF), 0, 8'h00);
    xfer(f[0:5], nakf());
    repeat (DROPC) @(posedge clk);
    xfer(f[6:$], none);
    cmp_outs(10'h000);
    $display("t_late done");
  endtask : t_late
  task automatic t_restart;
    xfer({8'h58, 8'h3A, 8'h31, mk(onoff(10'h3FF, 10'h3FF), 0, 8'h00)}, st(8'h39, 10'h3FF));
    cmp_outs(10'h3FF);
    $display("t_restart done");
  endtask : t_restart

  // ====
  // closing report
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // clock
  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done;
    end
  end
  // main sequence
  initial begin
    clk           = 1'b0;
    reset         = 1'b1;
    stall         = 1'b0;
    run_mode      = 1'b1;
    control_fault = 1'b0;
    input_points  = 12'hA5C;
    miscompares   = 0;
    total_checks  = 0;
    cycles        = 0;
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    cmp_outs(10'h000);
    t_onoff;
    t_mask;
    t_bad;
    t_late;
    t_restart;
    test_done;
  end
endmodule : aicf_framer_tb

/* aicf_host.sv */
// host model: sends command bytes, takes reply bytes
`timescale 1ns/1ps
module aicf_host (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       stall
);
  logic [7:0] txq[$];
  logic [7:0] got[$];
  logic [1:0] cnt;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
    cnt      = 2'h0;
  end
  // one byte per clock, idle line toggles
  always @(posedge clk) begin
    #1;
    if (txq.size() > 0) begin
      rx_valid = 1'b1;
      rx_data  = txq.pop_front();
    end else begin
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
    end
  end
  // reply sink, every reply kept for the bench to judge
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    #1;
    cnt      = cnt + 2'h1;
    tx_ready = !stall || cnt == 2'h0;
  end
endmodule : aicf_host

/* aicf_pkg.sv */
// constants shared by the ascii command framer and its reply fifo
package aicf_pkg;

  // ==========================================================================
  // frame characters
  localparam logic [7:0] CH_START = 8'h3A;   // ':'
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_ZERO  = 8'h30;   // '0', also off / non-control
  localparam logic [7:0] CH_ONE   = 8'h31;   // '1', also on / control
  localparam logic [7:0] CH_TWO   = 8'h32;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_UA    = 8'h41;   // 'A'
  localparam logic [7:0] CH_UF    = 8'h46;   // 'F'
  localparam logic [7:0] CH_SEP   = 8'h2C;   // ','
  localparam logic [7:0] CH_N     = 8'h4E;
  localparam logic [7:0] CH_K     = 8'h4B;
  localparam logic [7:0] CH_NOTRUN = 8'h31;  // control status when not running

  // ==========================================================================
  // lengths (function + data bytes)
  localparam logic [7:0] LEN_NAK   = 8'h05;
  localparam logic [7:0] LEN_STATE = 8'h36;  // 2 + 52
  localparam logic [7:0] LEN_ONOFF = 8'h17;  // 2 + 21
  localparam int         NUM_OUT   = 10;
  localparam int         NUM_IN    = 12;
  localparam int         SEP_POS   = 12;     // body index of the separator
  localparam logic [9:0] OUT_RESET = 10'h000;

  // ==========================================================================
  // timing
  localparam longint CLK_PERIOD_NS  = 100;
  localparam longint NAK_LIMIT_NS   = 64'd1_000_000_000;   // 1 s
  localparam longint DROP_LIMIT_NS  = 64'd5_000_000_000;   // 5 s
  localparam int     NAK_CYCLES     = int'(NAK_LIMIT_NS / CLK_PERIOD_NS);
  localparam int     DROP_CYCLES    = int'(DROP_LIMIT_NS / CLK_PERIOD_NS);
  localparam int     FIFO_WIDTH     = 8;
  localparam int     FIFO_DEPTH     = 32;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_LEN_HI = 3'b001,
    RX_LEN_LO = 3'b010,
    RX_BODY   = 3'b011,
    RX_LF     = 3'b100
  } aicf_rx_t;

endpackage : aicf_pkg
